/* File: src/mmc_pkg.sv */
// mmc_pkg: constants and carrier types for the memory map controller
// assumes a 32-bit processor address bus and word-wide internal sram
package mmc_pkg;
    localparam int          ADDR_W        = 32;
    localparam int          DATA_W        = 32;
    localparam int          SRAM_BYTES    = 8192;
    localparam int          SRAM_WORDS    = SRAM_BYTES / 4;
    localparam int          SRAM_AW       = $clog2(SRAM_WORDS);
    localparam logic [31:0] INT_MEM_TOP   = 32'h0040_0000;
    localparam logic [31:0] PERIPH_BASE   = 32'hffc0_0000;
    localparam logic [31:0] VECTOR_TOP    = 32'h0000_0020;
    localparam int          PERIPH_WIN_SH = 14;
    localparam int          INTC_WIN_SH   = 12;
    localparam logic [31:0] INTC_BASE     = 32'hffff_f000;
    localparam int          PERIPH_SLOTS  = 16;
    localparam int          BOOT_SAMPLES  = 10;
    localparam int          NUM_BANKS     = 8;
    localparam int          BANK_MIN_SH   = 20;
    localparam int          BANK_MAX_SH   = 24;

    typedef enum logic [1:0] {
        MMC_SZ_BYTE,
        MMC_SZ_HALF,
        MMC_SZ_WORD
    } mmc_size_t;

    typedef enum logic [1:0] {
        MMC_SRC_NONE,
        MMC_SRC_UNDEF,
        MMC_SRC_MISALIGN
    } mmc_abort_src_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        fetch;
        logic        user;
        mmc_size_t   size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mmc_req_t;

    typedef struct packed {
        logic        sel;
        logic        write;
        mmc_size_t   size;
        logic [2:0]  bank;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mmc_ext_req_t;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mmc_per_req_t;

    typedef struct packed {
        logic [3:0] wait_states;
        logic [1:0] float_cycles;
        logic       bus16;
        logic       valid;
    } mmc_bank_cfg_t;
endpackage

/* File: src/mmc_sram.sv */
// mmc_sram: word-wide internal memory with byte-lane write enables
// assumes one access per cycle; read data is registered
`default_nettype none
module mmc_sram #(
    parameter int WORDS = 2048,
    parameter int AW    = 11
) (
    input  wire logic          sys_clk,
    input  wire logic          en,
    input  wire logic [3:0]    we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [31:0]   wdata,
    output logic      [31:0]   rdata
);
    logic [31:0] mem [WORDS];

    always_ff @(posedge sys_clk)
    begin
        if (en)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (we[i])
                    mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
            end
            rdata <= mem[addr];
        end
    end
endmodule
`default_nettype wire

/* File: src/mmc_boot_strap.sv */
// mmc_boot_strap: catches the boot width strap over the final slow ticks
// assumes slow_tick is a one-cycle pulse per slow clock period
`default_nettype none
module mmc_boot_strap
    import mmc_pkg::*;
#(
    parameter int SAMPLES = 10
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic external_reset_n,
    input  wire logic slow_tick,
    input  wire logic boot_width_select,
    output logic      boot_8bit_ff
);
    logic [SAMPLES-1:0] hist_ff;
    logic               ext_rst_q_ff;

    // shift strap while pin reset is held, one sample per slow tick
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            hist_ff <= '0;
        else if (!external_reset_n && slow_tick)
            hist_ff <= {hist_ff[SAMPLES-2:0], boot_width_select};
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            ext_rst_q_ff <= 1'b0;
        else
            ext_rst_q_ff <= !external_reset_n;
    end

    // latch only on pin reset release; a watchdog reset keeps the mode
    // majority of the window rejects a lone glitch in the sample set
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            boot_8bit_ff <= 1'b1;
        else if (ext_rst_q_ff && external_reset_n)
            boot_8bit_ff <= ($countones(hist_ff) > (SAMPLES / 2));
    end
endmodule
`default_nettype wire

/* File: src/mmc_top.sv */
// mmc_top: address decode, remap, protection and abort for the core bus
// assumes a single-cycle request from the core and ready external units
`default_nettype none
// What this block does
// - decode address into memory, external, peripheral regions
// - route middle space to the external bus
// - little-endian lanes in sram, boot and external regions; peripherals get whole words
// - protection pin blocks user access to defined peripherals once shared_io_released is high
// - undefined peripheral addresses never abort
// - 8 KB sram, all sizes in one cycle
// - boot memory appears at zero after reset
// - boot width strap sampled before reset release
// - remap bit puts sram at zero
// - remap sticks until a reset
// - undefined external address raises an abort
// - misaligned access aborts but still executes
// - misaligned internal memory reads, peripherals never abort
// - forbidden protected write dropped without abort
// - record abort source, address and type
// - peripherals get word accesses only
// - 16 KB peripheral windows, 4 KB interrupt window
// - external banks 1 MB to 16 MB, own settings
// - watchdog reset keeps boot mode
module mmc_top
    import mmc_pkg::*;
#(
    parameter int              BANK_SHIFT = 20,
    parameter logic [15:0]     PERIPH_DEFINED = 16'hffff
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic                  external_reset_n,
    input  wire logic                  watchdog_reset,
    input  wire logic                  slow_tick,
    input  wire logic                  boot_width_select,
    input  wire logic                  protect_enable_pin,
    input  wire logic                  shared_io_released,
    input  wire logic                  remap_command_bit,
    input  wire mmc_pkg::mmc_req_t     core_req,
    input  wire logic [31:0]           ext_rdata,
    input  wire logic [31:0]           per_rdata,
    input  wire mmc_pkg::mmc_bank_cfg_t bank_cfg [8],
    output logic [31:0]                core_rdata,
    output logic                       core_abort,
    output logic                       core_prefetch_abort,
    output mmc_pkg::mmc_ext_req_t      ext_req,
    output mmc_pkg::mmc_per_req_t      per_req,
    output mmc_pkg::mmc_bank_cfg_t     ext_bank_cfg,
    output logic                       boot_chip_select,
    output logic                       boot_8bit,
    output logic                       remapped,
    output logic                       protect_active,
    output mmc_pkg::mmc_abort_src_t    abort_status,
    output logic [31:0]                abort_addr,
    output logic                       abort_was_fetch,
    output logic                       abort_was_write
);
    import mmc_pkg::*;

    typedef enum logic [1:0] {
        MMC_RG_SRAM,
        MMC_RG_BOOT,
        MMC_RG_EXT,
        MMC_RG_PER
    } mmc_region_t;

    // internal reset: pin, watchdog, or bench reset, ORed; any one of them asserts it
    logic        int_rst;
    logic        remap_ff;
    logic        prot_ff;
    mmc_region_t region;
    logic        misalign;
    logic        ext_undef;
    logic        per_defined;
    logic        per_block;
    logic        abort_now;
    logic [2:0]  bank;
    logic [3:0]  lanes;
    logic [31:0] lane_wdata;
    logic [31:0] sram_rdata;
    logic        sram_sel_ff;
    logic        boot_strap_8bit;

    assign int_rst = !rstn || !external_reset_n || watchdog_reset;

    function automatic logic is_misaligned(input mmc_size_t sz,
                                           input logic [1:0] lo);
        case (sz)
            MMC_SZ_HALF: is_misaligned = lo[0];
            MMC_SZ_WORD: is_misaligned = |lo;
            default:     is_misaligned = 1'b0;
        endcase
    endfunction

    // little-endian byte lanes: lowest address is the lowest byte
    function automatic logic [3:0] lane_mask(input mmc_size_t sz,
                                             input logic [1:0] lo);
        case (sz)
            MMC_SZ_BYTE: lane_mask = 4'h1 << lo;
            MMC_SZ_HALF: lane_mask = lo[1] ? 4'hc : 4'h3;
            default:     lane_mask = 4'hf;
        endcase
    endfunction

    function automatic logic [31:0] lane_data(input mmc_size_t sz,
                                              input logic [31:0] d);
        case (sz)
            MMC_SZ_BYTE: lane_data = {4{d[7:0]}};
            MMC_SZ_HALF: lane_data = {2{d[15:0]}};
            default:     lane_data = d;
        endcase
    endfunction

    // region decode
    always_comb
    begin
        if (core_req.addr < INT_MEM_TOP)
            region = remap_ff ? MMC_RG_SRAM : MMC_RG_BOOT;
        else if (core_req.addr >= PERIPH_BASE)
            region = MMC_RG_PER;
        else
            region = MMC_RG_EXT;
    end

    // interrupt controller owns a 4 KB window; other slots are 16 KB
    always_comb
    begin
        if (core_req.addr[31:INTC_WIN_SH] == INTC_BASE[31:INTC_WIN_SH])
            per_defined = 1'b1;
        else if (core_req.addr[31:PERIPH_WIN_SH] >=
                 INTC_BASE[31:PERIPH_WIN_SH])
            per_defined = 1'b0;
        else
            per_defined =
                PERIPH_DEFINED[core_req.addr[PERIPH_WIN_SH+3:PERIPH_WIN_SH]];
    end

    // bank index: banks are 2**BANK_SHIFT bytes in the external space
    assign bank = 3'(core_req.addr >> BANK_SHIFT);

    always_comb
    begin
        ext_undef = 1'b0;
        if (region == MMC_RG_EXT)
            ext_undef = !bank_cfg[bank].valid;
        else if (region == MMC_RG_BOOT)
            ext_undef = 1'b0;
    end

    assign misalign  = is_misaligned(core_req.size, core_req.addr[1:0]);
    assign per_block = prot_ff && core_req.user && per_defined;
    assign lanes     = lane_mask(core_req.size, core_req.addr[1:0]);
    assign lane_wdata = lane_data(core_req.size, core_req.wdata);

    // abort: undefined external, misaligned outside peripheral space, or protected user peripheral read
    // misaligned sram reads and peripheral accesses never abort
    always_comb
    begin
        abort_now = 1'b0;
        if (!core_req.valid)
            abort_now = 1'b0;
        else if (region == MMC_RG_PER)
            abort_now = per_block && !core_req.write;
        else if (region == MMC_RG_SRAM && !core_req.write)
            abort_now = 1'b0;
        else if (region == MMC_RG_EXT)
            abort_now = ext_undef || misalign;
        else
            abort_now = misalign;
    end

    // remap latches and holds until any reset
    always_ff @(posedge sys_clk)
    begin
        if (int_rst)
            remap_ff <= 1'b0;
        else if (remap_command_bit)
            remap_ff <= 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (int_rst)
            prot_ff <= 1'b0;
        else
            prot_ff <= protect_enable_pin && shared_io_released;
    end

    mmc_sram #(
        .WORDS (SRAM_WORDS),
        .AW    (SRAM_AW)
    ) u_sram (
        .sys_clk (sys_clk),
        .en      (core_req.valid && region == MMC_RG_SRAM),
        .we      (core_req.write ? lanes : 4'h0),
        .addr    (core_req.addr[SRAM_AW+1:2]),
        .wdata   (lane_wdata),
        .rdata   (sram_rdata)
    );

    // strap is caught only on the pin reset, not the watchdog
    mmc_boot_strap #(
        .SAMPLES (BOOT_SAMPLES)
    ) u_strap (
        .sys_clk           (sys_clk),
        .rstn              (rstn),
        .external_reset_n  (external_reset_n),
        .slow_tick         (slow_tick),
        .boot_width_select (boot_width_select),
        .boot_8bit_ff      (boot_strap_8bit)
    );

    // external requests: boot memory below remap goes to chip select zero
    always_ff @(posedge sys_clk)
    begin
        if (int_rst)
        begin
            ext_req          <= '0;
            ext_bank_cfg     <= '0;
            boot_chip_select <= 1'b0;
        end
        else
        begin
            ext_req.sel   <= core_req.valid &&
                             (region == MMC_RG_EXT || region == MMC_RG_BOOT)
                             && !(region == MMC_RG_EXT && ext_undef);
            ext_req.write <= core_req.write;
            ext_req.size  <= core_req.size;
            ext_req.bank  <= (region == MMC_RG_BOOT) ? 3'h0 : bank;
            ext_req.addr  <= core_req.addr;
            ext_req.wdata <= lane_wdata;
            ext_bank_cfg  <= (region == MMC_RG_BOOT) ? bank_cfg[0]
                                                     : bank_cfg[bank];
            boot_chip_select <= core_req.valid &&
                                region == MMC_RG_BOOT;
        end
    end

    // peripherals see words only; protected user writes are dropped
    always_ff @(posedge sys_clk)
    begin
        if (int_rst)
            per_req <= '0;
        else
        begin
            per_req.sel   <= core_req.valid && region == MMC_RG_PER &&
                             !per_block;
            per_req.write <= core_req.write;
            per_req.addr  <= {core_req.addr[31:2], 2'b00};
            per_req.wdata <= core_req.wdata;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (int_rst)
            sram_sel_ff <= 1'b0;
        else
            sram_sel_ff <= core_req.valid && region == MMC_RG_SRAM;
    end

    // read data: registered sram word, else external or peripheral data
    always_comb
    begin
        if (sram_sel_ff)
            core_rdata = sram_rdata;
        else if (per_req.sel)
            core_rdata = per_rdata;
        else
            core_rdata = ext_rdata;
    end

    // abort leaves with the access; the core samples it in the same slot
    always_ff @(posedge sys_clk)
    begin
        if (int_rst)
        begin
            core_abort          <= 1'b0;
            core_prefetch_abort <= 1'b0;
        end
        else
        begin
            core_abort          <= abort_now && !core_req.fetch;
            core_prefetch_abort <= abort_now && core_req.fetch;
        end
    end

    // last abort source, address and type
    always_ff @(posedge sys_clk)
    begin
        if (int_rst)
        begin
            abort_status    <= MMC_SRC_NONE;
            abort_addr      <= '0;
            abort_was_fetch <= 1'b0;
            abort_was_write <= 1'b0;
        end
        else if (abort_now)
        begin
            abort_status    <= misalign ? MMC_SRC_MISALIGN
                                        : MMC_SRC_UNDEF;
            abort_addr      <= core_req.addr;
            abort_was_fetch <= core_req.fetch;
            abort_was_write <= core_req.write;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            boot_8bit      <= 1'b1;
            remapped       <= 1'b0;
            protect_active <= 1'b0;
        end
        else
        begin
            boot_8bit      <= boot_strap_8bit;
            remapped       <= remap_ff;
            protect_active <= prot_ff;
        end
    end
endmodule
`default_nettype wire

/* File: test/mmc_far_model.sv */
// mmc_far_model: read data sources behind the external and peripheral buses
// assumes data is taken combinationally in the cycle after the request
`default_nettype none
module mmc_far_model
    import mmc_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire mmc_pkg::mmc_ext_req_t ext_req,
    input  wire mmc_pkg::mmc_per_req_t per_req,
    output logic [31:0]                ext_rdata,
    output logic [31:0]                per_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] junk_ff = 32'h0;
    // released buses wander, so stale data never matches by luck
    always_ff @(posedge sys_clk)
        junk_ff <= junk_ff + 32'h1357_9bdf;
    assign ext_rdata = ext_req.sel ? ~ext_req.addr : junk_ff;
    assign per_rdata = per_req.sel ? per_req.addr ^ 32'h5a5a_5a5a
                                   : ~junk_ff;
endmodule
`default_nettype wire

/* File: test/mmc_top_chk.sv */
// mmc_top_chk: port assertions for the memory map controller
// assumes mmc_pkg is compiled first; bound onto every mmc_top
`default_nettype none
module mmc_top_chk
    import mmc_pkg::*;
#(
    parameter int          BANK_SHIFT     = 20,
    parameter logic [15:0] PERIPH_DEFINED = 16'hffff
) (
    input wire logic                    sys_clk,
    input wire logic                    rstn,
    input wire logic                    external_reset_n,
    input wire logic                    watchdog_reset,
    input wire logic                    protect_enable_pin,
    input wire logic                    shared_io_released,
    input wire logic                    remap_command_bit,
    input wire mmc_pkg::mmc_req_t       core_req,
    input wire mmc_pkg::mmc_bank_cfg_t  bank_cfg [8],
    input wire logic                    core_abort,
    input wire logic                    core_prefetch_abort,
    input wire mmc_pkg::mmc_ext_req_t   ext_req,
    input wire mmc_pkg::mmc_per_req_t   per_req,
    input wire logic                    boot_chip_select,
    input wire logic                    remapped,
    input wire logic                    protect_active,
    input wire mmc_pkg::mmc_abort_src_t abort_status,
    input wire logic [31:0]             abort_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       ok, v, ext, per, bad, mis, ab;
    logic [2:0] bk;
    logic [3:0] sl;
    assign ok = rstn && external_reset_n && !watchdog_reset;
    assign v = core_req.valid;
    assign bk = core_req.addr[BANK_SHIFT+:3];
    assign sl = core_req.addr[17:14];
    assign ext = v && core_req.addr >= INT_MEM_TOP
                 && core_req.addr < PERIPH_BASE;
    assign per = v && core_req.addr >= PERIPH_BASE;
    // interrupt slot is defined only in its top 4 KB
    assign bad = protect_active && core_req.user && (core_req.addr >= INTC_BASE
                 || PERIPH_DEFINED[sl] && sl != 4'hf);
    assign mis = core_req.size == MMC_SZ_WORD ? |core_req.addr[1:0]
               : core_req.size == MMC_SZ_HALF && core_req.addr[0];
    assign ab = core_abort || core_prefetch_abort;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!ok);

    a_ext_route: assert property (ext && bank_cfg[bk].valid
        |=> ext_req.sel && ext_req.addr == $past(core_req.addr)) else $error("ext");
    a_undef_abort: assert property (ext && !bank_cfg[bk].valid
        |=> ab && !ext_req.sel) else $error("undefined bank");
    a_misalign_go: assert property (ext && bank_cfg[bk].valid && mis
        |=> ab && ext_req.sel && abort_status == MMC_SRC_MISALIGN) else $error("mis");
    a_per_quiet: assert property (per && !bad |=> !ab && per_req.sel
        && per_req.addr == {$past(core_req.addr[31:2]), 2'b00}) else $error("per");
    a_prot_read: assert property (per && bad && !core_req.write
        |=> ab && !per_req.sel) else $error("protected read");
    a_prot_write: assert property (per && bad && core_req.write
        |=> !ab && !per_req.sel) else $error("protected write");
    a_abort_addr: assert property (ab
        |-> abort_addr == $past(core_req.addr)) else $error("abort addr");
    a_record_hold: assert property ($past(ok) && !ab
        |-> $stable(abort_addr) && $stable(abort_status)) else $error("record");
    a_remap_sticky: assert property (remapped
        |=> remapped) else $error("remap lost");
    a_remap_set: assert property (remap_command_bit
        |-> ##[1:2] remapped) else $error("remap not set");
    a_boot_cs: assert property (v && !remapped && core_req.addr < 32'h100
        |=> boot_chip_select) else $error("boot select");
    // pins pass two flops: the internal latch, then the status output
    a_prot_level: assert property ($past(ok) && $past(ok, 2)
        |-> protect_active ==
            $past(protect_enable_pin && shared_io_released, 2))
        else $error("prot");
endmodule
bind mmc_top mmc_top_chk #(
    .BANK_SHIFT     (BANK_SHIFT),
    .PERIPH_DEFINED (PERIPH_DEFINED)
) CHK (.*);
`default_nettype wire

/* File: test/testbench.sv */
// testbench: directed access sequences for the memory map controller
// assumes package, design, far model and checker are compiled before it
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mmc_pkg::*;
    logic sys_clk = 0, rstn = 0, external_reset_n = 1, watchdog_reset = 0;
    logic slow_tick = 0, boot_width_select = 0, protect_enable_pin = 0;
    logic shared_io_released = 0, remap_command_bit = 0;
    logic core_abort, core_prefetch_abort, boot_chip_select, boot_8bit;
    logic remapped, protect_active, abort_was_fetch, abort_was_write;
    logic [31:0]    ext_rdata, per_rdata, core_rdata, abort_addr;
    mmc_req_t       core_req = '0;
    mmc_bank_cfg_t  bank_cfg [8];
    mmc_bank_cfg_t  ext_bank_cfg;
    mmc_ext_req_t   ext_req;
    mmc_per_req_t   per_req;
    mmc_abort_src_t abort_status;
    int             err_count = 0, cmp_count = 0, cyc = 0;
    logic [31:0]    pa [6] = '{32'hffe0_0000, 32'hffe0_0000, 32'hffe2_0000,
                               32'hffff_f000, 32'hffff_c000, 32'hffe0_0000};
    logic [1:0]     pe [6] = '{2'b10, 2'b00, 2'b01, 2'b10, 2'b01, 2'b01};

    mmc_top #(.PERIPH_DEFINED(16'h80ff)) DUT (.*);
    mmc_far_model FAR (.*);

    initial forever #5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) slow_tick <= cyc[1:0] == 2'h0;
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // one request per call; valid stays up so calls run back to back
    task automatic acc(input logic w, f, u, input mmc_size_t s,
                       input logic [31:0] a, d);
        core_req = '{1'b1, w, f, u, s, a, d};
        @(negedge sys_clk);
    endtask
    task automatic nop(input int n);
        core_req.valid = 1'b0;
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic pin_reset();
        external_reset_n = 0;
        repeat (60) @(negedge sys_clk);
        external_reset_n = 1;
        nop(2);
    endtask
    task automatic tend(input string n);
        $display("test %s finished, mismatches so far %0d", n, err_count);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        foreach (bank_cfg[i]) bank_cfg[i] = '{4'(i), 2'h1, 1'b0, i != 5};
        repeat (4) @(negedge sys_clk);
        chk(boot_8bit, 1);
        rstn = 1;
        pin_reset();
        chk(boot_8bit, 0);
        acc(0, 1, 0, MMC_SZ_WORD, 32'h0, 32'h0);
        chk({boot_chip_select, core_abort}, 2'b10);
        tend("boot");
        nop(1);
        remap_command_bit = 1;
        nop(1);
        remap_command_bit = 0;
        nop(2);
        chk(remapped, 1);
        acc(1, 0, 0, MMC_SZ_WORD, 32'h0, 32'h4433_2211);
        acc(1, 0, 0, MMC_SZ_BYTE, 32'h1, 32'habab_abab);
        acc(0, 1, 0, MMC_SZ_WORD, 32'h0, 32'h0);
        chk(core_rdata, 32'h4433_ab11);
        acc(1, 0, 0, MMC_SZ_WORD, 32'h1ffc, 32'h0);
        acc(1, 0, 0, MMC_SZ_HALF, 32'h1ffe, 32'h7788_7788);
        acc(0, 0, 0, MMC_SZ_WORD, 32'h1ffc, 32'h0);
        chk(core_rdata, 32'h7788_0000);
        tend("sram");
        acc(0, 0, 0, MMC_SZ_WORD, 32'h0040_0010, 32'h0);
        chk({ext_req.sel, core_abort}, 2'b10);
        chk(core_rdata, ~32'h0040_0010);
        chk(ext_bank_cfg.wait_states, 4'h4);
        chk({ext_req.bank, ext_req.size}, {3'h4, MMC_SZ_WORD});
        acc(0, 0, 0, MMC_SZ_WORD, 32'hffbf_fffc, 32'h0);
        chk(ext_req.sel, 1);
        acc(1, 0, 0, MMC_SZ_WORD, 32'h0050_0000, 32'h1);
        chk({core_abort, ext_req.sel}, 2'b10);
        chk({abort_status, abort_was_write}, {MMC_SRC_UNDEF, 1'b1});
        chk(abort_addr, 32'h0050_0000);
        acc(0, 1, 0, MMC_SZ_WORD, 32'h0050_0004, 32'h0);
        chk({core_prefetch_abort, abort_was_fetch}, 2'b11);
        acc(0, 0, 0, MMC_SZ_HALF, 32'h0040_0001, 32'h0);
        chk({core_abort, ext_req.sel}, 2'b11);
        chk(abort_status, MMC_SRC_MISALIGN);
        tend("external");
        acc(1, 0, 1, MMC_SZ_BYTE, 32'hffe0_4003, 32'h5555_5555);
        chk(per_req.addr, 32'hffe0_4000);
        chk({per_req.write, per_req.wdata[30:0]}, 32'hd555_5555);
        chk({core_abort, per_req.sel}, 2'b01);
        protect_enable_pin = 1;
        shared_io_released = 1;
        nop(2);
        chk(protect_active, 1);
        for (int i = 0; i < 6; i++)
        begin
            acc(i == 1, 0, i != 5, MMC_SZ_WORD, pa[i], 32'h1);
            chk({core_abort, per_req.sel}, pe[i]);
        end
        shared_io_released = 0;
        nop(2);
        acc(0, 0, 1, MMC_SZ_WORD, 32'hffe0_0000, 32'h0);
        chk({core_abort, per_req.sel}, 2'b01);
        chk(core_rdata, 32'hffe0_0000 ^ 32'h5a5a_5a5a);
        tend("peripheral");
        nop(1);
        chk(remapped, 1);
        boot_width_select = 1;
        watchdog_reset = 1;
        nop(5);
        watchdog_reset = 0;
        nop(2);
        chk({boot_8bit, remapped}, 2'b00);
        pin_reset();
        chk(boot_8bit, 1);
        tend("reset");
        report_and_stop();
    end
endmodule
`default_nettype wire
